// >>> hw/skip_decode.sv
// timer skip, serial start and supply-detect enable instruction decoder
//
// Behaviour
// - the timer-4 skip opcode skips the next instruction when its gate bit is 0 and the timer-4 flag is 1, else the next executes.
// - a timer-4 skip that is taken clears the timer-4 request flag, and without a skip the flag keeps its value.
// - while bit 3 of the second interrupt control register is 1 the timer-4 skip opcode is a no-operation.
// - the timer-5 skip opcode is gated by bit 1 of that register and skips when the bit is 0 and the timer-5 flag is 1.
// - a timer-5 skip that is taken clears the timer-5 request flag, and with the flag at 0 the next executes.
// - the serial start opcode clears the serial request flag and starts a transfer in a single cycle.
// - the supply-detect opcode sets an enable that keeps the supply drop detector alive in power-down.
module skip_decode (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // instruction from the sequencer
   input wire logic instr_valid,
   input wire logic [9:0] instr_code,
   // flag sources
   input wire logic tmr4_event,
   input wire logic tmr5_event,
   input wire logic serial_done,
   // to the sequencer and peripherals
   output logic skip_next_r,
   output logic instr_done_r,
   output logic serial_start_r,
   output logic supply_detect_en_r,
   output logic irq_r,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [3:0] intr_ctrl_two_r;
   logic [3:0] intr_ctrl_two_nxt;
   logic [3:0] irq_mask_r;
   logic [3:0] irq_mask_nxt;
   logic [3:0] irq_status_r;
   logic [3:0] irq_status_nxt;
   logic tmr4_flag_r;
   logic tmr4_flag_nxt;
   logic tmr5_flag_r;
   logic tmr5_flag_nxt;
   logic serial_flag_r;
   logic serial_flag_nxt;
   logic skip_next_nxt;
   logic instr_done_nxt;
   logic serial_start_nxt;
   logic supply_detect_en_nxt;
   logic irq_nxt;
   logic ack_r;
   logic ack_nxt;
   logic waitrequest_nxt;
   logic [31:0] readdata_nxt;

   // ----------------------------------------
   // opcode decode
   // ----------------------------------------
   // codes outside the four fall through with no effect, not even a done pulse
   wire logic match_skip4 = (instr_code == skip_decode_pkg::OP_SKIP_TMR4);
   wire logic match_skip5 = (instr_code == skip_decode_pkg::OP_SKIP_TMR5);
   wire logic match_serial = (instr_code == skip_decode_pkg::OP_SERIAL_START);
   wire logic match_supply = (instr_code == skip_decode_pkg::OP_SUPPLY_DETECT);

   wire logic dec_skip4 = instr_valid && match_skip4;
   wire logic dec_skip5 = instr_valid && match_skip5;
   wire logic dec_serial = instr_valid && match_serial;
   wire logic dec_supply = instr_valid && match_supply;
   wire logic dec_any = dec_skip4 || dec_skip5 || dec_serial || dec_supply;

   // ----------------------------------------
   // timer-4 skip channel
   // ----------------------------------------
   // gate bit set turns the skip opcode into a no-operation
   wire logic gate4 = intr_ctrl_two_r[skip_decode_pkg::TMR4_GATE_BIT];
   wire logic take4 = dec_skip4 && !gate4 && tmr4_flag_r;

   // a new timer event in the clearing cycle is kept: set wins
   assign tmr4_flag_nxt = tmr4_event || (tmr4_flag_r && !take4);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tmr4_flag_r <= 1'b0;
      end else begin
         tmr4_flag_r <= tmr4_flag_nxt;
      end
   end

   // ----------------------------------------
   // timer-5 skip channel
   // ----------------------------------------
   wire logic gate5 = intr_ctrl_two_r[skip_decode_pkg::TMR5_GATE_BIT];
   wire logic take5 = dec_skip5 && !gate5 && tmr5_flag_r;

   assign tmr5_flag_nxt = tmr5_event || (tmr5_flag_r && !take5);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tmr5_flag_r <= 1'b0;
      end else begin
         tmr5_flag_r <= tmr5_flag_nxt;
      end
   end

   // ----------------------------------------
   // serial start
   // ----------------------------------------
   assign serial_flag_nxt = serial_done || (serial_flag_r && !dec_serial);
   assign serial_start_nxt = dec_serial;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_flag_r <= 1'b0;
      end else begin
         serial_flag_r <= serial_flag_nxt;
      end
   end

   // one-cycle strobe; the serial unit counts its own bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_start_r <= 1'b0;
      end else begin
         serial_start_r <= serial_start_nxt;
      end
   end

   // ----------------------------------------
   // skip and done pulses
   // ----------------------------------------
   // every result is one cycle; no carry port exists, so carry is never written
   wire logic skip_taken = take4 || take5;
   assign skip_next_nxt = skip_taken;
   assign instr_done_nxt = dec_any;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         skip_next_r <= 1'b0;
      end else begin
         skip_next_r <= skip_next_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         instr_done_r <= 1'b0;
      end else begin
         instr_done_r <= instr_done_nxt;
      end
   end

   // ----------------------------------------
   // supply drop detector enable
   // ----------------------------------------
   // enable stays until reset: no opcode here turns the detector off
   assign supply_detect_en_nxt = supply_detect_en_r || dec_supply;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         supply_detect_en_r <= 1'b0;
      end else begin
         supply_detect_en_r <= supply_detect_en_nxt;
      end
   end

   // ----------------------------------------
   // avalon-mm decode
   // ----------------------------------------
   wire logic bus_req = avs_read || avs_write;
   wire logic req_new = bus_req && !ack_r;
   wire logic rd_load = avs_read && !ack_r;
   wire logic wr_ack = avs_write && ack_r;
   wire logic sel_ctrl = (avs_address == skip_decode_pkg::OFS_INTR_CTRL_TWO);
   wire logic sel_flags = (avs_address == skip_decode_pkg::OFS_FLAGS);
   wire logic sel_status = (avs_address == skip_decode_pkg::OFS_IRQ_STATUS);
   wire logic sel_mask = (avs_address == skip_decode_pkg::OFS_IRQ_MASK);
   wire logic wr_ctrl = wr_ack && sel_ctrl;
   wire logic wr_status = wr_ack && sel_status;
   wire logic wr_mask = wr_ack && sel_mask;

   // ----------------------------------------
   // interrupt status
   // ----------------------------------------
   wire logic [3:0] ev_vec = {skip_taken, serial_done, tmr5_event, tmr4_event};
   wire logic [3:0] w1c = wr_status ? avs_writedata[3:0] : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < skip_decode_pkg::NUM_EV; gi++) begin : g_ev
         // event in the clearing cycle wins over the write-one-to-clear
         assign irq_status_nxt[gi] = ev_vec[gi] || (irq_status_r[gi] && !w1c[gi]);
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_r <= 4'h0;
      end else begin
         irq_status_r <= irq_status_nxt;
      end
   end

   // ----------------------------------------
   // interrupt output
   // ----------------------------------------
   // built from the next status so the line follows status in the same cycle
   assign irq_nxt = |(irq_status_nxt & irq_mask_r);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   // one wait state per access; ack_r masks the request in its ack cycle,
   // so a master that releases right after the ack is not served twice
   assign ack_nxt = req_new;
   assign waitrequest_nxt = !req_new;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= waitrequest_nxt;
      end
   end

   // ----------------------------------------
   // readback
   // ----------------------------------------
   wire logic [3:0] flags_vec = {supply_detect_en_r, serial_flag_r, tmr5_flag_r, tmr4_flag_r};
   wire logic [3:0] rd_ctrl = sel_ctrl ? intr_ctrl_two_r : 4'h0;
   wire logic [3:0] rd_flags = sel_flags ? flags_vec : 4'h0;
   wire logic [3:0] rd_status = sel_status ? irq_status_r : 4'h0;
   wire logic [3:0] rd_mask = sel_mask ? irq_mask_r : 4'h0;
   // unmapped offsets and bits 31:4 read as zero
   assign readdata_nxt = {28'h000_0000, rd_ctrl | rd_flags | rd_status | rd_mask};

   // loaded as waitrequest drops, then held until the next read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_load) begin
         avs_readdata <= readdata_nxt;
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   assign intr_ctrl_two_nxt = wr_ctrl ? avs_writedata[3:0] : intr_ctrl_two_r;
   assign irq_mask_nxt = wr_mask ? avs_writedata[3:0] : irq_mask_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         intr_ctrl_two_r <= skip_decode_pkg::RST_INTR_CTRL_TWO;
      end else begin
         intr_ctrl_two_r <= intr_ctrl_two_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask_r <= skip_decode_pkg::RST_IRQ_MASK;
      end else begin
         irq_mask_r <= irq_mask_nxt;
      end
   end

endmodule // skip_decode

// >>> hw/skip_decode_pkg.sv
// constants for the timer skip / serial start decoder
package skip_decode_pkg;
   // ----------------------------------------
   // opcodes, ten-bit instruction words
   // ----------------------------------------
   localparam int CODE_W = 10;
   localparam logic [9:0] OP_SKIP_TMR4 = 10'h283;
   localparam logic [9:0] OP_SKIP_TMR5 = 10'h284;
   localparam logic [9:0] OP_SERIAL_START = 10'h29E;
   localparam logic [9:0] OP_SUPPLY_DETECT = 10'h293;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [3:0] OFS_INTR_CTRL_TWO = 4'h0;
   localparam logic [3:0] OFS_FLAGS = 4'h4;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
   localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int TMR4_GATE_BIT = 3;
   localparam int TMR5_GATE_BIT = 1;
   localparam int FLG_TMR4 = 0;
   localparam int FLG_TMR5 = 1;
   localparam int FLG_SERIAL = 2;
   localparam int FLG_SUPPLY = 3;
   localparam int EV_TMR4_SET = 0;
   localparam int EV_TMR5_SET = 1;
   localparam int EV_SERIAL_DONE = 2;
   localparam int EV_SKIP_TAKEN = 3;
   localparam int NUM_EV = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [3:0] RST_INTR_CTRL_TWO = 4'h0;
   localparam logic [3:0] RST_IRQ_MASK = 4'h0;
endpackage : skip_decode_pkg

// >>> verif/skip_decode_monitor.sv
// port checks for the skip / serial start decoder
module skip_decode_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // instruction side
   input wire logic instr_valid,
   input wire logic [9:0] instr_code,
   input wire logic skip_next_r,
   input wire logic instr_done_r,
   input wire logic serial_start_r,
   input wire logic supply_detect_en_r
);
   timeunit 1ns;
   timeprecision 1ps;
   wire t4 = instr_valid && instr_code == skip_decode_pkg::OP_SKIP_TMR4;
   wire t5 = instr_valid && instr_code == skip_decode_pkg::OP_SKIP_TMR5;
   wire ser = instr_valid && instr_code == skip_decode_pkg::OP_SERIAL_START;
   wire sup = instr_valid && instr_code == skip_decode_pkg::OP_SUPPLY_DETECT;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // back-to-back starts merge, so only a lone start must give one pulse
   sequence s_lone_start;
      ser ##1 !ser;
   endsequence
   sequence s_one_pulse;
      serial_start_r ##1 !serial_start_r;
   endsequence
   a_tmr4_done: assert property (t4 |=> instr_done_r)
      else $error("timer-4 skip took more than one cycle");
   a_tmr5_done: assert property (t5 |=> instr_done_r)
      else $error("timer-5 skip took more than one cycle");
   a_skip_cause: assert property (skip_next_r |-> $past(t4 || t5))
      else $error("skip without a skip opcode");
   a_start_pulse: assert property (s_lone_start |-> s_one_pulse)
      else $error("serial start not a single pulse");
   a_start_cause: assert property (serial_start_r |-> $past(ser))
      else $error("serial start without its opcode");
   a_detect_set: assert property (sup |=> supply_detect_en_r)
      else $error("detector enable not set");
   a_detect_hold: assert property (supply_detect_en_r |=> supply_detect_en_r)
      else $error("detector enable dropped");
   a_done_cause: assert property (instr_done_r |-> $past(t4 || t5 || ser || sup))
      else $error("done without one of the four opcodes");
endmodule // skip_decode_monitor

bind skip_decode skip_decode_monitor skip_decode_monitor_i (.clk(clk), .reset_n(reset_n),
   .instr_valid(instr_valid), .instr_code(instr_code), .skip_next_r(skip_next_r),
   .instr_done_r(instr_done_r), .serial_start_r(serial_start_r),
   .supply_detect_en_r(supply_detect_en_r));

// >>> verif/skip_decode_tb.sv
// self-checking bench for the skip / serial start decoder
module skip_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic tmr4_event = 1'b0, tmr5_event = 1'b0, serial_done = 1'b0;
   logic [9:0] instr_code = 10'h000;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic skip_next_r, instr_done_r, serial_start_r, supply_detect_en_r, irq_r, avs_waitrequest;
   int miscompares = 0, compares = 0, cyc = 0;
   always #10 clk = ~clk;
   skip_decode skip_decode_i (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr_code(instr_code), .tmr4_event(tmr4_event), .tmr5_event(tmr5_event),
      .serial_done(serial_done), .skip_next_r(skip_next_r), .instr_done_r(instr_done_r),
      .serial_start_r(serial_start_r), .supply_detect_en_r(supply_detect_en_r),
      .irq_r(irq_r), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   // on a read d is the expected data; held until waitrequest is seen low
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      if (!w) chk("readdata", d, avs_readdata);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task exec(input logic [9:0] c, input logic s, input logic d = 1'b1);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_code <= c;
      @(posedge clk);
      instr_valid <= 1'b0;
      @(negedge clk);
      chk("skip_next_r", {31'h0, s}, {31'h0, skip_next_r});
      chk("instr_done_r", {31'h0, d}, {31'h0, instr_done_r});
   endtask
   task ev(input logic [2:0] v);
      @(posedge clk);
      {serial_done, tmr5_event, tmr4_event} <= v;
      @(posedge clk);
      {serial_done, tmr5_event, tmr4_event} <= 3'h0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_of_test;
      end
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      acc(1'b0, 4'h0, 32'h0);
      acc(1'b0, 4'hC, 32'h0);
      acc(1'b0, 4'h2, 32'h0);
      acc(1'b1, 4'h2, 32'hF);
      acc(1'b0, 4'h4, 32'h0);
      for (int i = 0; i < 2; i++) begin
         exec(i ? 10'h284 : 10'h283, 1'b0);
         ev(3'h1 << i);
         acc(1'b1, 4'h0, i ? 32'h2 : 32'h8);
         exec(i ? 10'h284 : 10'h283, 1'b0);
         acc(1'b0, 4'h4, 32'h1 << i);
         acc(1'b1, 4'h0, i ? 32'h8 : 32'h2);
         exec(i ? 10'h284 : 10'h283, 1'b1);
         acc(1'b0, 4'h4, 32'h0);
         acc(1'b1, 4'h0, 32'h0);
      end
      // event in the cycle of a taken skip: the flag must come back set
      ev(3'h1);
      fork
         exec(10'h283, 1'b1);
         ev(3'h1);
      join
      acc(1'b0, 4'h4, 32'h1);
      exec(10'h283, 1'b1);
      acc(1'b0, 4'h4, 32'h0);
      exec(10'h282, 1'b0, 1'b0);
      ev(3'h4);
      acc(1'b0, 4'h4, 32'h4);
      exec(10'h29E, 1'b0);
      chk("serial_start_r", 32'h1, {31'h0, serial_start_r});
      acc(1'b0, 4'h4, 32'h0);
      acc(1'b0, 4'h8, 32'hF);
      chk("irq_r", 32'h0, {31'h0, irq_r});
      acc(1'b1, 4'hC, 32'h4);
      repeat (2) @(negedge clk);
      chk("irq_r", 32'h1, {31'h0, irq_r});
      acc(1'b1, 4'h8, 32'hF);
      acc(1'b0, 4'h8, 32'h0);
      repeat (2) @(negedge clk);
      chk("irq_r", 32'h0, {31'h0, irq_r});
      exec(10'h293, 1'b0);
      acc(1'b0, 4'h4, 32'h8);
      chk("supply_detect_en_r", 32'h1, {31'h0, supply_detect_en_r});
      // second reset in mid-run
      acc(1'b1, 4'hC, 32'hF);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk("supply_detect_en_r", 32'h0, {31'h0, supply_detect_en_r});
      chk("irq_r", 32'h0, {31'h0, irq_r});
      acc(1'b0, 4'hC, 32'h0);
      exec(10'h283, 1'b0);
      end_of_test;
   end
endmodule // skip_decode_tb
